// ==== inc/mec_pkg.sv ====
// Constants shared by the line codec unit and its receive decoder.
// Assumes a single 50 MHz system clock for all logic.
package mec_pkg;

   // ****************************************************************
   // Clock and timing
   // ****************************************************************
   localparam int CLK_PERIOD_NS = 20;
   // Collision indication hold after the last collision pair edge
   localparam int COLL_HOLD_NS  = 200;
   // Decoder ignores edges this long after a mid-cell edge (least)
   localparam int RX_GUARD_NS   = 75;
   // Decoder end-of-frame timeout after the last bit (longest)
   localparam int RX_EOF_NS     = 150;

   localparam logic [3:0] COLL_HOLD_CYC =
      4'(COLL_HOLD_NS / CLK_PERIOD_NS);
   localparam logic [3:0] RX_GUARD_CYC  =
      4'((RX_GUARD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam logic [3:0] RX_EOF_CYC    =
      4'(RX_EOF_NS / CLK_PERIOD_NS);

   // ****************************************************************
   // Reset values and encodings
   // ****************************************************************
   localparam logic [3:0] CNT_ZERO      = 4'h0;
   localparam logic [3:0] CNT_ONE       = 4'h1;
   localparam logic       STRAP_EXT     = 1'h1;

   typedef enum logic [1:0] {
      MEC_IDLE = 2'h0,
      MEC_SEND = 2'h1,
      MEC_TAIL = 2'h3
   } mec_enc_state_t;

endpackage : mec_pkg

// ==== inc/mec_rx_if.sv ====
// Signals between the codec top and its Manchester receive decoder.
// Assumes both ends run on the same system clock.
`timescale 1ns/1ps
interface mec_rx_if;
   logic line;
   logic squelch_ok;
   logic carrier;
   logic data;
   logic bit_strobe;

   modport dec (input line, input squelch_ok,
                output carrier, output data, output bit_strobe);
   modport top (output line, output squelch_ok,
                input carrier, input data, input bit_strobe);
endinterface : mec_rx_if

// ==== design/mec_rx_decoder.sv ====
// Manchester receive decoder: recovers bit strobe, NRZ data and carrier.
// Assumes the line and squelch level are synchronous to i_clock.
`timescale 1ns/1ps
module mec_rx_decoder (
   input  wire logic i_clock,
   input  wire logic i_sys_rst,
   mec_rx_if.dec     rx
);
   import mec_pkg::*;

   // ****************************************************************
   // Edge detection and lock
   // ****************************************************************
   logic       line_q;
   logic       line_prev;
   logic [3:0] guard;
   logic [3:0] eof_cnt;
   logic       carrier;
   logic       data;
   logic       strobe;

   wire line_edge  = line_q != line_prev;
   // Only a qualified mid-cell edge carries data
   wire take_edge  = line_edge && guard == CNT_ZERO && rx.squelch_ok;
   wire eof_expire = carrier && !take_edge && eof_cnt == CNT_ONE;

   always_ff @(posedge i_clock or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         line_q    <= 1'h0;
         line_prev <= 1'h0;
      end else begin
         line_q    <= rx.line;
         line_prev <= line_q;
      end
   end

   always_ff @(posedge i_clock or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         guard   <= CNT_ZERO;
         eof_cnt <= CNT_ZERO;
         carrier <= 1'h0;
         data    <= 1'h0;
         strobe  <= 1'h0;
      end else if (take_edge) begin
         guard   <= RX_GUARD_CYC;
         eof_cnt <= RX_EOF_CYC;
         carrier <= 1'h1;
         data    <= line_q;
         strobe  <= 1'h1;
      end else begin
         strobe <= 1'h0;
         if (guard != CNT_ZERO) begin
            guard <= guard - CNT_ONE;
         end
         if (eof_cnt != CNT_ZERO) begin
            eof_cnt <= eof_cnt - CNT_ONE;
         end
         if (eof_expire) begin
            carrier <= 1'h0;
         end
      end
   end

   assign rx.carrier    = carrier;
   assign rx.data       = data;
   assign rx.bit_strobe = strobe;

   // ****************************************************************
   // Checks
   // ****************************************************************
   default clocking cb @(posedge i_clock); endclocking
   default disable iff (i_sys_rst);

   property p_no_lock_in_squelch;
      (!rx.squelch_ok && !carrier) |=> !carrier;
   endproperty
   a_no_lock_in_squelch: assert property (p_no_lock_in_squelch)
      else $error("decoder locked while squelched");

   property p_end_of_frame;
      strobe ##1 (!strobe)[*7] |=> !carrier;
   endproperty
   a_end_of_frame: assert property (p_end_of_frame)
      else $error("end of frame not seen in time");

   property p_data_from_line;
      take_edge |=> (strobe && data == $past(line_q));
   endproperty
   a_data_from_line: assert property (p_data_from_line)
      else $error("recovered bit differs from line");

   c_frame_end: cover property (carrier ##1 !carrier);

endmodule : mec_rx_decoder

// ==== design/mec_unit.sv ====
// Line codec unit: Manchester encoder, decoder, collision translator,
// clock divider and external codec bypass.
// Assumes all inputs are synchronous to i_clock and the oscillator
// input is slower than half the system clock rate.
`timescale 1ns/1ps

module mec_unit (
   input  wire logic i_clock,
   input  wire logic i_sys_rst,
   input  wire logic i_codec_select_strap,
   input  wire logic i_idle_level_strap,
   input  wire logic i_oscillator_input,
   output logic      o_oscillator_feedback_output,
   output logic      o_transmit_bit_clock,
   input  wire logic i_mac_tx_enable,
   input  wire logic i_mac_tx_data,
   output logic      o_mac_rx_carrier,
   output logic      o_mac_rx_data,
   output logic      o_mac_rx_clock,
   output logic      o_mac_collision,
   output logic      o_mac_retry_request,
   output logic      o_tx_pos,
   output logic      o_tx_neg,
   input  wire logic i_rx_line,
   input  wire logic i_rx_squelch_ok,
   input  wire logic i_collision_pair_positive,
   input  wire logic i_collision_pair_negative,
   input  wire logic i_ext_rx_carrier,
   input  wire logic i_ext_rx_data,
   input  wire logic i_ext_rx_clock,
   input  wire logic i_ext_collision,
   output logic      o_pin_tx_enable,
   output logic      o_pin_tx_data,
   output logic      o_pin_rx_carrier,
   output logic      o_pin_rx_data,
   output logic      o_pin_rx_clock,
   output logic      o_pin_collision
);
   import mec_pkg::*;

   // ****************************************************************
   // Strap capture
   // ****************************************************************
   logic strap_taken;
   logic ext_mode;
   logic idle_level;

   // Straps are caught once, the first edge after reset release
   always_ff @(posedge i_clock or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         strap_taken <= 1'h0;
         ext_mode    <= STRAP_EXT;
         idle_level  <= 1'h0;
      end else if (!strap_taken) begin
         strap_taken <= 1'h1;
         ext_mode    <= i_codec_select_strap;
         idle_level  <= i_idle_level_strap;
      end
   end

   // ****************************************************************
   // Oscillator divider
   // ****************************************************************
   logic osc_q;
   logic osc_prev;
   logic tbc;

   wire osc_rise   = osc_q && !osc_prev;
   wire cell_start = osc_rise && !tbc;
   wire cell_mid   = osc_rise && tbc;

   always_ff @(posedge i_clock or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         osc_q    <= 1'h0;
         osc_prev <= 1'h0;
         tbc      <= 1'h0;
      end else begin
         osc_q    <= i_oscillator_input;
         osc_prev <= osc_q;
         if (osc_rise) begin
            tbc <= !tbc;
         end
      end
   end

   // ****************************************************************
   // Collision translator
   // ****************************************************************
   logic       coll_q;
   logic       coll_prev;
   logic [3:0] coll_cnt;

   wire coll_edge   = coll_q != coll_prev;
   wire coll_active = coll_cnt != CNT_ZERO;

   // A running pattern keeps reloading the hold counter
   always_ff @(posedge i_clock or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         coll_q    <= 1'h0;
         coll_prev <= 1'h0;
         coll_cnt  <= CNT_ZERO;
      end else begin
         coll_q    <= i_collision_pair_positive &&
                      !i_collision_pair_negative;
         coll_prev <= coll_q;
         if (coll_edge) begin
            coll_cnt <= COLL_HOLD_CYC;
         end else if (coll_active) begin
            coll_cnt <= coll_cnt - CNT_ONE;
         end
      end
   end

   // ****************************************************************
   // Manchester encoder
   // ****************************************************************
   mec_enc_state_t state;
   mec_enc_state_t next_state;
   logic           sym;
   logic           next_sym;
   logic           last_bit;
   logic           next_last_bit;
   logic           next_abort;
   logic           aborted;

   // An aborted frame stays off the line until the MAC drops enable
   always_ff @(posedge i_clock or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         aborted <= 1'h0;
      end else if (next_abort) begin
         aborted <= 1'h1;
      end else if (!i_mac_tx_enable) begin
         aborted <= 1'h0;
      end
   end

   always_comb begin
      next_state    = state;
      next_sym      = sym;
      next_last_bit = last_bit;
      next_abort    = 1'h0;
      if (ext_mode) begin
         next_state = MEC_IDLE;
      end else if (coll_active && state != MEC_IDLE) begin
         next_state = MEC_IDLE;
         next_abort = 1'h1;
      end else if (cell_start) begin
         case (state)
            MEC_IDLE, MEC_SEND: begin
               if (i_mac_tx_enable && !aborted) begin
                  next_state    = MEC_SEND;
                  next_last_bit = i_mac_tx_data;
                  next_sym      = !i_mac_tx_data;
               end else if (state == MEC_SEND) begin
                  // Zero ends low: rise at the cell boundary
                  next_state = last_bit ? MEC_IDLE : MEC_TAIL;
                  next_sym   = 1'h1;
               end
            end
            default: begin
               next_state = MEC_IDLE;
            end
         endcase
      end else if (cell_mid) begin
         case (state)
            MEC_SEND: begin
               next_sym = last_bit;
            end
            MEC_TAIL: begin
               next_state = MEC_IDLE;
            end
            default: begin
               next_sym = sym;
            end
         endcase
      end
   end

   always_ff @(posedge i_clock or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         state    <= MEC_IDLE;
         sym      <= 1'h1;
         last_bit <= 1'h0;
      end else begin
         state    <= next_state;
         sym      <= next_sym;
         last_bit <= next_last_bit;
      end
   end

   wire enc_idle  = state == MEC_IDLE;
   wire next_pos  = enc_idle ? !idle_level : sym;
   wire next_neg  = enc_idle ? 1'h0 : !sym;

   // ****************************************************************
   // Receive decoder
   // ****************************************************************
   mec_rx_if rx ();

   assign rx.line       = i_rx_line;
   assign rx.squelch_ok = i_rx_squelch_ok;

   mec_rx_decoder u_dec (
      .i_clock   (i_clock),
      .i_sys_rst (i_sys_rst),
      .rx        (rx.dec)
   );

   // ****************************************************************
   // MAC side selection and pins
   // ****************************************************************
   wire sel_carrier = ext_mode ? i_ext_rx_carrier : rx.carrier;
   wire sel_data    = ext_mode ? i_ext_rx_data    : rx.data;
   wire sel_clock   = ext_mode ? i_ext_rx_clock   : rx.bit_strobe;
   wire sel_coll    = ext_mode ? i_ext_collision  : coll_active;

   always_ff @(posedge i_clock or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         o_oscillator_feedback_output <= 1'h1;
         o_transmit_bit_clock         <= 1'h0;
         o_tx_pos                     <= 1'h0;
         o_tx_neg                     <= 1'h0;
         o_mac_retry_request          <= 1'h0;
      end else begin
         o_oscillator_feedback_output <= !osc_q;
         o_transmit_bit_clock         <= tbc;
         o_tx_pos                     <= next_pos;
         o_tx_neg                     <= next_neg;
         o_mac_retry_request          <= next_abort;
      end
   end

   always_ff @(posedge i_clock or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         o_mac_rx_carrier <= 1'h0;
         o_mac_rx_data    <= 1'h0;
         o_mac_rx_clock   <= 1'h0;
         o_mac_collision  <= 1'h0;
         o_pin_tx_enable  <= 1'h0;
         o_pin_tx_data    <= 1'h0;
         o_pin_rx_carrier <= 1'h0;
         o_pin_rx_data    <= 1'h0;
         o_pin_rx_clock   <= 1'h0;
         o_pin_collision  <= 1'h0;
      end else begin
         o_mac_rx_carrier <= sel_carrier;
         o_mac_rx_data    <= sel_data;
         o_mac_rx_clock   <= sel_clock;
         o_mac_collision  <= sel_coll;
         o_pin_tx_enable  <= i_mac_tx_enable;
         o_pin_tx_data    <= i_mac_tx_data;
         o_pin_rx_carrier <= sel_carrier;
         o_pin_rx_data    <= sel_data;
         o_pin_rx_clock   <= sel_clock;
         o_pin_collision  <= sel_coll;
      end
   end

   // ****************************************************************
   // Checks
   // ****************************************************************
   default clocking cb @(posedge i_clock); endclocking
   default disable iff (i_sys_rst);

   property p_strap_held;
      strap_taken |=> $stable(ext_mode) && $stable(idle_level);
   endproperty
   a_strap_held: assert property (p_strap_held)
      else $error("strap changed after capture");

   property p_pins_mirror;
      !ext_mode |=> (o_pin_rx_data == o_mac_rx_data &&
                     o_pin_collision == o_mac_collision);
   endproperty
   a_pins_mirror: assert property (p_pins_mirror)
      else $error("observation pins differ from MAC side");

   property p_bypass;
      (strap_taken && ext_mode) |=>
         (o_mac_rx_data == $past(i_ext_rx_data) && state == MEC_IDLE);
   endproperty
   a_bypass: assert property (p_bypass)
      else $error("external codec bypass not applied");

   property p_first_half;
      (cell_start && state != MEC_TAIL && i_mac_tx_enable && !aborted &&
       !ext_mode && !coll_active) |=> ##1 (o_tx_pos == !$past(i_mac_tx_data, 2));
   endproperty
   a_first_half: assert property (p_first_half)
      else $error("first half cell not inverted bit");

   property p_second_half;
      (cell_mid && state == MEC_SEND && !coll_active && !ext_mode)
         |=> ##1 (o_tx_pos == last_bit && o_tx_neg == !last_bit);
   endproperty
   a_second_half: assert property (p_second_half)
      else $error("second half cell not true bit");

   property p_final_rise;
      (state == MEC_SEND && next_state == MEC_TAIL) |=> ##1 o_tx_pos;
   endproperty
   a_final_rise: assert property (p_final_rise)
      else $error("frame did not end on a rising level");

   property p_idle_level;
      (strap_taken && enc_idle && $past(enc_idle)) |=>
         (o_tx_pos == !idle_level && !o_tx_neg);
   endproperty
   a_idle_level: assert property (p_idle_level)
      else $error("idle line level wrong");

   property p_collision;
      (coll_edge && !ext_mode) |=> ##1 o_mac_collision;
   endproperty
   a_collision: assert property (p_collision)
      else $error("collision pattern not indicated");

   property p_abort;
      (coll_active && !ext_mode && state != MEC_IDLE) |=>
         (state == MEC_IDLE ##0 o_mac_retry_request);
   endproperty
   a_abort: assert property (p_abort)
      else $error("collision did not abort the frame");

   property p_divide;
      osc_rise |=> ##1 (o_transmit_bit_clock != $past(o_transmit_bit_clock));
   endproperty
   a_divide: assert property (p_divide)
      else $error("transmit clock not halved oscillator");

   c_frame_sent: cover property (state == MEC_SEND ##[1:40] enc_idle);
   c_tail:       cover property (state == MEC_TAIL);
   c_abort:      cover property (o_mac_retry_request);
   c_rx_bit:     cover property (o_mac_rx_clock && !ext_mode);

endmodule : mec_unit

// ==== tb/mec_xcvr_model.sv ====
// Transceiver model: receive line with squelch, collision pair.
// Assumes the bench calls send_frame from a falling clock edge.
`timescale 1ns/1ps
module mec_xcvr_model (
   input  wire logic i_clock,
   input  wire logic i_coll_on,
   output logic      o_rx_line,
   output logic      o_rx_squelch_ok,
   output logic      o_coll_pos,
   output logic      o_coll_neg
);
   logic [2:0]  phase;
   logic [15:0] frame;
   logic [4:0]  left;

   initial begin
      phase           = 3'h0;
      left            = 5'h00;
      frame           = 16'h0000;
      o_rx_line       = 1'b0;
      o_rx_squelch_ok = 1'b0;
      o_coll_pos      = 1'b0;
      o_coll_neg      = 1'b0;
   end

   // ********
   // Cell of five cycles: three inverted, two true
   // ********
   always @(negedge i_clock) begin
      phase      <= (phase == 3'h4) ? 3'h0 : phase + 3'h1;
      o_coll_pos <= i_coll_on && (phase < 3'h3);
      o_coll_neg <= i_coll_on && (phase >= 3'h3);
      if (left != 5'h00) begin
         o_rx_squelch_ok <= 1'b1;
         o_rx_line       <= (phase < 3'h3) ? ~frame[0] : frame[0];
         if (phase == 3'h4) begin
            frame <= frame >> 1;
            left  <= left - 5'h01;
         end
      end else begin
         // Released line carries noise, never a steady level
         o_rx_squelch_ok <= 1'b0;
         o_rx_line       <= ~o_rx_line;
      end
   end

   task automatic send_frame(input logic [15:0] bits);
      do @(negedge i_clock); while (phase != 3'h4);
      frame <= bits;
      left  <= 5'h10;
      do @(negedge i_clock); while (left != 5'h00);
   endtask : send_frame
endmodule : mec_xcvr_model

// ==== tb/mec_unit_test.sv ====
// Bench for the line codec unit: divider, encoder, decoder, collision.
// Assumes the package and the transceiver model are compiled first.
`timescale 1ns/1ps
module mec_unit_test;
   import mec_pkg::*;

   logic i_clock, i_sys_rst, i_codec_select_strap, i_idle_level_strap;
   logic i_oscillator_input, i_mac_tx_enable, i_mac_tx_data;
   logic i_ext_rx_carrier, i_ext_rx_data, i_ext_rx_clock, i_ext_collision;
   wire  i_rx_line, i_rx_squelch_ok;
   wire  i_collision_pair_positive, i_collision_pair_negative;
   wire  o_oscillator_feedback_output, o_transmit_bit_clock;
   wire  o_mac_rx_carrier, o_mac_rx_data, o_mac_rx_clock;
   wire  o_mac_collision, o_mac_retry_request, o_tx_pos, o_tx_neg;
   wire  o_pin_tx_enable, o_pin_tx_data, o_pin_rx_carrier;
   wire  o_pin_rx_data, o_pin_rx_clock, o_pin_collision;
   int   mismatches = 0;
   int   n_checks   = 0;
   int   cycles     = 0;
   int   n_strobe   = 0;
   logic [7:0] rx_sr    = 8'h00;
   logic [2:0] osc_step = 3'h0;
   logic       coll_on  = 1'b0;

   mec_unit mec_unit_i (.*);
   mec_xcvr_model mec_xcvr_model_i (
      .i_clock         (i_clock),
      .i_coll_on       (coll_on),
      .o_rx_line       (i_rx_line),
      .o_rx_squelch_ok (i_rx_squelch_ok),
      .o_coll_pos      (i_collision_pair_positive),
      .o_coll_neg      (i_collision_pair_negative)
   );

   // ********
   // Clock, oscillator, receive monitor, timeout
   // ********
   always #10 i_clock = ~i_clock;

   // Two oscillator rises in every five system cycles
   always @(negedge i_clock) begin
      osc_step           <= (osc_step == 3'h4) ? 3'h0 : osc_step + 3'h1;
      i_oscillator_input <= (osc_step == 3'h0) || (osc_step == 3'h2);
      if (o_mac_rx_clock === 1'b1) begin
         n_strobe <= n_strobe + 1;
         rx_sr    <= {o_mac_rx_data, rx_sr[7:1]};
      end
   end

   always @(posedge i_clock) begin
      cycles <= cycles + 1;
      if (cycles == 5000) begin
         mismatches++;
         close_out();
      end
   end

   task automatic chk(input string name, input logic exp, input logic got);
      n_checks++;
      if (got !== exp) begin
         mismatches++;
         $display("MISMATCH %s expected %b seen %b", name, exp, got);
      end
   endtask : chk

   task automatic close_out();
      $display("checks %0d mismatches %0d", n_checks, mismatches);
      if (mismatches == 0 && n_checks > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask : close_out

   task automatic do_reset(input logic codec, input logic idle);
      @(negedge i_clock);
      i_sys_rst            = 1'b1;
      i_codec_select_strap = codec;
      i_idle_level_strap   = idle;
      repeat (12) @(negedge i_clock);
      chk("fb_in_reset", 1'b1, o_oscillator_feedback_output);
      chk("pos_in_reset", 1'b0, o_tx_pos);
      i_sys_rst = 1'b0;
      repeat (4) @(negedge i_clock);
      chk("idle_pos", ~idle, o_tx_pos);
      chk("idle_neg", 1'b0, o_tx_neg);
   endtask : do_reset

   task automatic t_divider();
      int   n_tbc;
      int   n_fb;
      logic p_tbc;
      logic p_fb;
      n_tbc = 0;
      n_fb  = 0;
      p_tbc = o_transmit_bit_clock;
      p_fb  = o_oscillator_feedback_output;
      repeat (100) begin
         @(negedge i_clock);
         if (o_transmit_bit_clock !== p_tbc) n_tbc++;
         if (o_oscillator_feedback_output !== p_fb) n_fb++;
         p_tbc = o_transmit_bit_clock;
         p_fb  = o_oscillator_feedback_output;
      end
      chk("tbc_rate", 1'b1, n_tbc >= 39 && n_tbc <= 41);
      chk("fb_rate", 1'b1, n_fb >= 79 && n_fb <= 81);
   endtask : t_divider

   task automatic t_encode(input logic [7:0] b, input logic idle);
      for (int i = 0; i <= 8; i++) begin
         @(negedge o_transmit_bit_clock);
         @(negedge i_clock);
         i_mac_tx_enable = (i < 8);
         i_mac_tx_data   = (i < 8) ? b[i] : 1'b0;
         @(negedge i_clock);
         chk("pin_tx_data", i_mac_tx_data, o_pin_tx_data);
         if (i > 0) chk("second_half", b[i-1], o_tx_pos);
         @(posedge o_transmit_bit_clock);
         repeat (2) @(negedge i_clock);
         if (i < 8) begin
            chk("first_half_pos", ~b[i], o_tx_pos);
            chk("first_half_neg", b[i], o_tx_neg);
         end else begin
            chk("end_pos", 1'b1, o_tx_pos);
            chk("end_neg", 1'b0, o_tx_neg);
         end
      end
      repeat (12) @(negedge i_clock);
      chk("after_pos", ~idle, o_tx_pos);
   endtask : t_encode

   task automatic t_collide();
      int k;
      @(negedge i_clock);
      i_mac_tx_enable = 1'b1;
      i_mac_tx_data   = 1'b1;
      repeat (12) @(negedge i_clock);
      coll_on <= 1'b1;
      k = 0;
      while (o_mac_retry_request !== 1'b1 && k < 12) begin
         @(negedge i_clock);
         k++;
      end
      chk("retry", 1'b1, o_mac_retry_request);
      chk("collision", 1'b1, o_mac_collision);
      @(negedge i_clock);
      chk("abort_pos", 1'b0, o_tx_pos);
      chk("abort_neg", 1'b0, o_tx_neg);
      chk("retry_single", 1'b0, o_mac_retry_request);
      repeat (12) @(negedge i_clock);
      chk("abort_held", 1'b0, o_tx_pos);
      i_mac_tx_enable = 1'b0;
      repeat (20) @(negedge i_clock);
      chk("collision_held", 1'b1, o_mac_collision);
      coll_on <= 1'b0;
      k = 0;
      while (o_mac_collision !== 1'b0 && k < 30) begin
         @(negedge i_clock);
         k++;
      end
      chk("coll_release", 1'b1, k <= int'(COLL_HOLD_CYC) + 6);
   endtask : t_collide

   task automatic t_decode();
      int s0;
      int k;
      i_ext_collision  = 1'b1;
      i_ext_rx_carrier = 1'b1;
      s0 = n_strobe;
      repeat (30) @(negedge i_clock);
      chk("no_strobe", 1'b1, n_strobe == s0);
      chk("ext_coll_unused", 1'b0, o_mac_collision);
      chk("ext_crs_unused", 1'b0, o_mac_rx_carrier);
      mec_xcvr_model_i.send_frame(16'hC3AA);
      chk("carrier", 1'b1, o_mac_rx_carrier);
      chk("pin_carrier", 1'b1, o_pin_rx_carrier);
      k = 0;
      while (o_mac_rx_carrier !== 1'b0 && k < 30) begin
         @(negedge i_clock);
         k++;
      end
      chk("frame_end", 1'b1, k <= int'(RX_EOF_CYC) + 4);
      chk("rx_byte", 1'b1, rx_sr === 8'hC3);
      i_ext_collision  = 1'b0;
      i_ext_rx_carrier = 1'b0;
   endtask : t_decode

   task automatic t_external();
      for (int v = 1; v >= 0; v--) begin
         i_ext_rx_carrier = v[0];
         i_ext_rx_data    = v[0];
         i_ext_rx_clock   = v[0];
         i_ext_collision  = v[0];
         i_mac_tx_enable  = v[0];
         i_mac_tx_data    = v[0];
         repeat (12) @(negedge i_clock);
         chk("mac_carrier", v[0], o_mac_rx_carrier);
         chk("mac_data", v[0], o_mac_rx_data);
         chk("mac_clock", v[0], o_mac_rx_clock);
         chk("mac_coll", v[0], o_mac_collision);
         chk("pin_data", v[0], o_pin_rx_data);
         chk("pin_clock", v[0], o_pin_rx_clock);
         chk("pin_coll", v[0], o_pin_collision);
         chk("pin_tx_en", v[0], o_pin_tx_enable);
         chk("bypass_pos", 1'b1, o_tx_pos);
         chk("bypass_neg", 1'b0, o_tx_neg);
      end
   endtask : t_external

   initial begin
      i_clock              = 1'b0;
      i_sys_rst            = 1'b1;
      i_codec_select_strap = 1'b0;
      i_idle_level_strap   = 1'b0;
      i_oscillator_input   = 1'b0;
      i_mac_tx_enable      = 1'b0;
      i_mac_tx_data        = 1'b0;
      i_ext_rx_carrier     = 1'b0;
      i_ext_rx_data        = 1'b0;
      i_ext_rx_clock       = 1'b0;
      i_ext_collision      = 1'b0;
      do_reset(1'b0, 1'b1);
      t_divider();
      t_encode(8'h35, 1'b1);
      t_collide();
      do_reset(1'b0, 1'b0);
      t_encode(8'hA5, 1'b0);
      t_decode();
      do_reset(1'b1, 1'b0);
      t_external();
      close_out();
   end
endmodule : mec_unit_test
